// File: cic_device.sv
/*
  Device end: interrupt flag, enable and error-condition registers of a
  CAN controller, the active-low interrupt pin and the pending-source code.
  Assumes the protocol engine supplies one-cycle event pulses, live
  buffer-occupied levels and the two error counters, all synchronous.
*/
`timescale 1ns/1ps

// Notes on behaviour
// [R1] TX empty event sets flag when enabled
// [R2] Host clears TX flag by writing zero
// [R3] RX load event sets flag when enabled
// [R4] RX flag set right after end-of-frame
// [R5] Host clears RX flag by writing zero
// [R6] Any message error sets flag; enable gates pin
// [R7] Bus activity in sleep sets wake flag
// [R8] Wake interrupt ends sleep mode
// [R9] Host clears wake flag
// [R10] Error enable: overflow or state change interrupts
// [R11] Valid message into busy buffer sets overrun
// [R12] Overrun bit cleared only by host
// [R13] Receive warning at counter 96
// [R14] Transmit warning at counter 96
// [R15] Receive passive above 127
// [R16] Transmit passive above 127
// [R17] Bus-off beyond 255
// [R18] Pending while any flag stays set; code counts a flag as pending only while its enable bit is also set
// [R19] Clear ignored while cause persists
// [R20] Enable register bit layout, reset zero
// [R21] Pin low while enabled interrupt pending
// [R22] Three-bit code of highest pending source
// [R23] Request is OR of flag AND enable
module cic_device (
  cic_if.dev              bus,
  input  wire logic       tx_empty_evt_i,   // One-cycle pulse; tx_evt_sel_i picks the buffers.
  input  wire logic [2:0] tx_empty_lvl_i,
  input  wire logic [1:0] rx_load_evt_i,    // Pulse after end of frame.
  input  wire logic [1:0] rx_full_lvl_i,
  input  wire logic [1:0] rx_target_i,      // Buffer chosen by the filter.
  input  wire logic       rx_valid_i,       // Assembled message accepted.
  input  wire logic [2:0] tx_evt_sel_i,
  input  wire logic       msg_error_i,
  input  wire logic       sleep_req_i,
  input  wire logic       bus_activity_i,
  input  wire logic [8:0] rx_err_cnt_i,
  input  wire logic [8:0] tx_err_cnt_i,
  output logic            sleep_o,
  output logic [2:0]      pending_source_code_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic [7:0] irq_source_enable_r, irq_source_enable_nxt;
  logic [7:0] irq_source_flags_r,  irq_source_flags_nxt;
  logic [1:0] rx_buffer_overrun_r, rx_buffer_overrun_nxt;
  logic [4:0] err_state_r;
  logic [4:0] err_state_nxt;
  logic       sleep_r, sleep_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] set_v, cond_v, error_condition_reg;
  logic [2:0] tx_set;
  logic [1:0] ovr_set;
  logic       err_change;
  logic [7:0] pend;
  logic       wr_en, wr_fl, wr_ec;

  assign wr_en = bus.wr && (bus.addr == cic_pkg::ADDR_IRQ_SOURCE_ENABLE);
  assign wr_fl = bus.wr && (bus.addr == cic_pkg::ADDR_IRQ_SOURCE_FLAGS);
  assign wr_ec = bus.wr && (bus.addr == cic_pkg::ADDR_ERROR_CONDITION);

  // ==========================================================================
  // Error state decode
  // ==========================================================================
  // Live counter thresholds; order is bus-off, tx/rx passive, tx/rx warn.
  always_comb begin
    err_state_nxt[4] = tx_err_cnt_i > cic_pkg::BUS_OFF_LIMIT;  // see [R17]
    err_state_nxt[3] = tx_err_cnt_i > cic_pkg::PASSIVE_LIMIT;  // see [R16]
    err_state_nxt[2] = rx_err_cnt_i > cic_pkg::PASSIVE_LIMIT;  // see [R15]
    err_state_nxt[1] = tx_err_cnt_i >= cic_pkg::WARN_LIMIT;    // see [R14]
    err_state_nxt[0] = rx_err_cnt_i >= cic_pkg::WARN_LIMIT;    // see [R13]
  end

  assign err_change = (err_state_nxt != err_state_r);
  assign ovr_set    = (rx_valid_i ? rx_target_i : 2'h0) & rx_full_lvl_i; // see [R11]

  // Assembled error condition register view.
  always_comb begin
    error_condition_reg                       = cic_pkg::RESET_BYTE;
    error_condition_reg[cic_pkg::EC_RX1_OVR]  = rx_buffer_overrun_r[1];
    error_condition_reg[cic_pkg::EC_RX0_OVR]  = rx_buffer_overrun_r[0];
    error_condition_reg[cic_pkg::EC_BUS_OFF]  = err_state_r[4];
    error_condition_reg[cic_pkg::EC_TX_PASS]  = err_state_r[3];
    error_condition_reg[cic_pkg::EC_RX_PASS]  = err_state_r[2];
    error_condition_reg[cic_pkg::EC_TX_WARN]  = err_state_r[1];
    error_condition_reg[cic_pkg::EC_RX_WARN]  = err_state_r[0];
    error_condition_reg[cic_pkg::EC_ANY_WARN] = |err_state_r[1:0];
  end

  // ==========================================================================
  // Flag set and hold conditions
  // ==========================================================================
  // Set events per flag; a flag only sets if its enable is on, except the
  // message error flag, which always records the event.
  always_comb begin
    tx_set = tx_empty_evt_i ? (tx_evt_sel_i & tx_empty_lvl_i) : 3'h0;    // see [R1]
    set_v = 8'h00;
    set_v[cic_pkg::BIT_MSG_ERROR] = msg_error_i;                            // see [R6]
    set_v[cic_pkg::BIT_WAKE]      = sleep_r && bus_activity_i
                                    && irq_source_enable_r[cic_pkg::BIT_WAKE]; // see [R7]
    set_v[cic_pkg::BIT_ERR_STATE] = (err_change || (|ovr_set))
                                    && irq_source_enable_r[cic_pkg::BIT_ERR_STATE]; // see [R10]
    set_v[cic_pkg::BIT_TX2] = tx_set[2] && irq_source_enable_r[cic_pkg::BIT_TX2]; // see [R1]
    set_v[cic_pkg::BIT_TX1] = tx_set[1] && irq_source_enable_r[cic_pkg::BIT_TX1]; // see [R1]
    set_v[cic_pkg::BIT_TX0] = tx_set[0] && irq_source_enable_r[cic_pkg::BIT_TX0]; // see [R1]
    set_v[cic_pkg::BIT_RX1] = rx_load_evt_i[1]
                              && irq_source_enable_r[cic_pkg::BIT_RX1]; // see [R3] [R4]
    set_v[cic_pkg::BIT_RX0] = rx_load_evt_i[0]
                              && irq_source_enable_r[cic_pkg::BIT_RX0]; // see [R3] [R4]
    // Conditions that keep a flag from being cleared while they last.
    cond_v = 8'h00;
    cond_v[cic_pkg::BIT_TX2] = 1'b0;
    cond_v[cic_pkg::BIT_RX1] = rx_full_lvl_i[1] && rx_load_evt_i[1];
    cond_v[cic_pkg::BIT_RX0] = rx_full_lvl_i[0] && rx_load_evt_i[0];
    cond_v[cic_pkg::BIT_ERR_STATE] = |rx_buffer_overrun_r;                 // see [R19]
    cond_v[cic_pkg::BIT_WAKE] = sleep_r && bus_activity_i;
  end

  // ==========================================================================
  // Register next values
  // ==========================================================================
  // Writes, sets and protected clears; a flag or overrun set beats a clear, a wake beats a sleep request.
  always_comb begin
    irq_source_enable_nxt = irq_source_enable_r;
    if (wr_en) begin
      irq_source_enable_nxt = bus.wdata;                                  // see [R20]
    end
    irq_source_flags_nxt = irq_source_flags_r;
    if (wr_fl) begin
      // Host writes may clear (or set, for test) any flag unless held.
      irq_source_flags_nxt = bus.wdata
                             | (irq_source_flags_r & cond_v); // see [R2] [R5] [R9] [R19]
    end
    irq_source_flags_nxt = irq_source_flags_nxt | set_v;
    rx_buffer_overrun_nxt = rx_buffer_overrun_r;
    if (wr_ec) begin
      rx_buffer_overrun_nxt = rx_buffer_overrun_r &
        {bus.wdata[cic_pkg::EC_RX1_OVR], bus.wdata[cic_pkg::EC_RX0_OVR]}; // see [R12]
    end
    rx_buffer_overrun_nxt = rx_buffer_overrun_nxt | ovr_set;             // see [R11]
    sleep_nxt = sleep_r;
    if (sleep_req_i) begin
      sleep_nxt = 1'b1;
    end
    if (set_v[cic_pkg::BIT_WAKE]) begin
      sleep_nxt = 1'b0;                                                   // see [R8]
    end
    rdata_nxt = cic_pkg::RESET_BYTE;
    if (bus.rd) begin
      if (bus.addr == cic_pkg::ADDR_IRQ_SOURCE_ENABLE) begin
        rdata_nxt = irq_source_enable_r;
      end else if (bus.addr == cic_pkg::ADDR_IRQ_SOURCE_FLAGS) begin
        rdata_nxt = irq_source_flags_r;
      end else if (bus.addr == cic_pkg::ADDR_ERROR_CONDITION) begin
        rdata_nxt = error_condition_reg;
      end else if (bus.addr == cic_pkg::ADDR_STATUS) begin
        rdata_nxt = {4'h0, pending_source_code_o, 1'b0};
      end else begin
        rdata_nxt = cic_pkg::RESET_BYTE;
      end
    end
  end

  // Register all state.
  always_ff @(posedge bus.clk_i or negedge bus.rst_b_i) begin
    if (!bus.rst_b_i) begin
      irq_source_enable_r <= cic_pkg::RESET_BYTE;
      irq_source_flags_r  <= cic_pkg::RESET_BYTE;
      rx_buffer_overrun_r <= 2'h0;
      err_state_r         <= 5'h00;
      sleep_r             <= 1'b0;
      rdata_r             <= cic_pkg::RESET_BYTE;
    end else begin
      irq_source_enable_r <= irq_source_enable_nxt;
      irq_source_flags_r  <= irq_source_flags_nxt;
      rx_buffer_overrun_r <= rx_buffer_overrun_nxt;
      err_state_r         <= err_state_nxt;
      sleep_r             <= sleep_nxt;
      rdata_r             <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Interrupt pin and pending code
  // ==========================================================================
  assign pend = irq_source_flags_r & irq_source_enable_r;                // see [R23] [R18]

  // Priority encode: lowest code wins.
  always_comb begin
    pending_source_code_o = cic_pkg::CODE_NONE;                           // see [R22]
    if (pend[cic_pkg::BIT_ERR_STATE]) begin
      pending_source_code_o = cic_pkg::CODE_ERR;
    end else if (pend[cic_pkg::BIT_WAKE]) begin
      pending_source_code_o = cic_pkg::CODE_WAKE;
    end else if (pend[cic_pkg::BIT_TX0]) begin
      pending_source_code_o = cic_pkg::CODE_TX0;
    end else if (pend[cic_pkg::BIT_TX1]) begin
      pending_source_code_o = cic_pkg::CODE_TX1;
    end else if (pend[cic_pkg::BIT_TX2]) begin
      pending_source_code_o = cic_pkg::CODE_TX2;
    end else if (pend[cic_pkg::BIT_RX0]) begin
      pending_source_code_o = cic_pkg::CODE_RX0;
    end else if (pend[cic_pkg::BIT_RX1]) begin
      pending_source_code_o = cic_pkg::CODE_RX1;
    end
  end

  assign bus.int_b = !(|pend);                                            // see [R21] [R6]
  assign bus.rdata = rdata_r;
  assign sleep_o   = sleep_r;

endmodule : cic_device

// File: cic_pkg.sv
/*
  Shared constants for the CAN controller interrupt logic: register
  offsets, bit positions of the enable, flag and error-condition registers,
  error counter thresholds and the pending-source codes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cic_pkg;

  // ==========================================================================
  // Register offsets on the device register port
  // ==========================================================================
  localparam logic [7:0] ADDR_IRQ_SOURCE_ENABLE = 8'h2B;
  localparam logic [7:0] ADDR_IRQ_SOURCE_FLAGS  = 8'h2C;
  localparam logic [7:0] ADDR_ERROR_CONDITION   = 8'h2D;
  localparam logic [7:0] ADDR_STATUS            = 8'h0E;

  // ==========================================================================
  // Bit positions shared by the enable and flag registers
  // ==========================================================================
  localparam int BIT_MSG_ERROR = 7;
  localparam int BIT_WAKE      = 6;
  localparam int BIT_ERR_STATE = 5;
  localparam int BIT_TX2       = 4;
  localparam int BIT_TX1       = 3;
  localparam int BIT_TX0       = 2;
  localparam int BIT_RX1       = 1;
  localparam int BIT_RX0       = 0;

  // ==========================================================================
  // Bit positions of the error condition register
  // ==========================================================================
  localparam int EC_RX1_OVR   = 7;
  localparam int EC_RX0_OVR   = 6;
  localparam int EC_BUS_OFF   = 5;
  localparam int EC_TX_PASS   = 4;
  localparam int EC_RX_PASS   = 3;
  localparam int EC_TX_WARN   = 2;
  localparam int EC_RX_WARN   = 1;
  localparam int EC_ANY_WARN  = 0;

  // ==========================================================================
  // Error counter thresholds and reset values
  // ==========================================================================
  localparam logic [8:0] WARN_LIMIT    = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
  localparam logic [8:0] BUS_OFF_LIMIT = 9'h0FF;
  localparam logic [7:0] RESET_BYTE    = 8'h00;

  // ==========================================================================
  // Pending-source codes, lower is higher priority
  // ==========================================================================
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_ERR  = 3'h1;
  localparam logic [2:0] CODE_WAKE = 3'h2;
  localparam logic [2:0] CODE_TX0  = 3'h3;
  localparam logic [2:0] CODE_TX1  = 3'h4;
  localparam logic [2:0] CODE_TX2  = 3'h5;
  localparam logic [2:0] CODE_RX0  = 3'h6;
  localparam logic [2:0] CODE_RX1  = 3'h7;

  // Host access sequencer states.
  typedef enum logic [1:0] {
    CIC_H_IDLE,
    CIC_H_WAIT,
    CIC_H_DONE
  } cic_host_state_t;

endpackage : cic_pkg

// File: cic_if.sv
/*
  Carrier between the interrupt logic and its host: a plain register port
  (address, write data, strobes, read data one cycle later) and the
  active-low interrupt pin.
  Assumes one shared clock and reset driven by the testbench.
*/
`timescale 1ns/1ps
interface cic_if (
  input wire logic clk_i,
  input wire logic rst_b_i
);
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       int_b;

  modport dev (
    input  clk_i, rst_b_i, addr, wdata, wr, rd,
    output rdata, int_b
  );
  modport host (
    input  clk_i, rst_b_i, rdata, int_b,
    output addr, wdata, wr, rd
  );
endinterface : cic_if

// File: cic_host.sv
/*
  Host end: executes one register read or write on request, returns the
  read data, and exposes the interrupt pin level.
  Assumes a single request at a time; start is ignored while busy.
*/
`timescale 1ns/1ps
module cic_host (
  cic_if.host        bus,
  input  wire logic       start_i,
  input  wire logic       write_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic            busy_o,
  output logic            done_o,
  output logic [7:0]      rdata_o,
  output logic            irq_o
);

  // ==========================================================================
  // Access sequencer
  // ==========================================================================
  cic_pkg::cic_host_state_t st_r, st_nxt;
  logic [7:0] addr_r, addr_nxt, wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic       wr_r, wr_nxt, rd_r, rd_nxt;
  logic       rd_op_r, rd_op_nxt;  // Current access is a read.

  // Next state: strobe one cycle, capture read data the cycle after.
  always_comb begin
    st_nxt    = st_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    wr_nxt    = 1'b0;
    rd_nxt    = 1'b0;
    rd_op_nxt = rd_op_r;
    case (st_r)
      cic_pkg::CIC_H_IDLE: begin
        if (start_i) begin
          addr_nxt  = addr_i;
          wdata_nxt = wdata_i;
          wr_nxt    = write_i; // see [R2]
          rd_nxt    = !write_i;
          rd_op_nxt = !write_i;
          st_nxt    = cic_pkg::CIC_H_WAIT;
        end
      end
      cic_pkg::CIC_H_WAIT: begin
        st_nxt = cic_pkg::CIC_H_DONE;
      end
      default: begin
        // Only a read may replace the held read data.
        if (rd_op_r) begin
          rdata_nxt = bus.rdata;
        end
        st_nxt = cic_pkg::CIC_H_IDLE;
      end
    endcase
  end

  // Registers of the sequencer.
  always_ff @(posedge bus.clk_i or negedge bus.rst_b_i) begin
    if (!bus.rst_b_i) begin
      st_r    <= cic_pkg::CIC_H_IDLE;
      addr_r  <= cic_pkg::RESET_BYTE;
      wdata_r <= cic_pkg::RESET_BYTE;
      rdata_r <= cic_pkg::RESET_BYTE;
      wr_r    <= 1'b0;
      rd_r    <= 1'b0;
      rd_op_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      wr_r    <= wr_nxt;
      rd_r    <= rd_nxt;
      rd_op_r <= rd_op_nxt;
    end
  end

  // Bus drive and user outputs.
  assign bus.addr  = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.wr    = wr_r;
  assign bus.rd    = rd_r;
  assign busy_o    = (st_r != cic_pkg::CIC_H_IDLE);
  assign done_o    = (st_r == cic_pkg::CIC_H_DONE);
  assign rdata_o   = rdata_r;
  assign irq_o     = !bus.int_b; // see [R21]

endmodule : cic_host

// File: cic_sva.sv
/*
  Checker for the register port and interrupt pin between the two ends.
  Assumes it is instantiated beside the interface and sees its plain signals.
*/
`timescale 1ns/1ps
module cic_sva (
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       int_b
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  logic [7:0] en_r;
  logic [7:0] en_nxt;
  logic       unmapped;

  // ==========================================================================
  // Shadow of the enable register, kept from observed writes.
  // ==========================================================================
  always_comb begin
    en_nxt = en_r;
    if (wr && addr == cic_pkg::ADDR_IRQ_SOURCE_ENABLE) begin
      en_nxt = wdata;
    end
  end

  // Registers the shadow; it resets to zero like the real register.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      en_r <= 8'h00;
    end else begin
      en_r <= en_nxt;
    end
  end

  // Addresses that decode to nothing.
  assign unmapped = addr != cic_pkg::ADDR_IRQ_SOURCE_ENABLE && addr != cic_pkg::ADDR_STATUS &&
                    addr != cic_pkg::ADDR_IRQ_SOURCE_FLAGS && addr != cic_pkg::ADDR_ERROR_CONDITION;

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  enable_read_a: assert property (rd && addr == cic_pkg::ADDR_IRQ_SOURCE_ENABLE |=>
      rdata == $past(en_r))
    else $error("enable register read differs from last write");
  unmapped_read_a: assert property (rd && unmapped |=> rdata == 8'h00)
    else $error("unmapped address read not zero");
  pin_masked_a: assert property (en_r == 8'h00 |-> int_b)
    else $error("pin low with every source disabled");
  pin_flags_a: assert property (rd && addr == cic_pkg::ADDR_IRQ_SOURCE_FLAGS |=>
      (((rdata & $past(en_r)) != 8'h00) == !$past(int_b)))
    else $error("pin level disagrees with enabled flags");
  // The message error source has no code, so only a shown code implies a low pin.
  code_pin_a: assert property (rd && addr == cic_pkg::ADDR_STATUS |=>
      ((rdata[3:1] == cic_pkg::CODE_NONE) || !$past(int_b)))
    else $error("pending code shown while the pin is released");
  pin_release_a: assert property ($rose(int_b) |-> $past(wr))
    else $error("pin released without a host write");
  strobe_gap_a: assert property ((wr || rd) |=> !(wr || rd) [*2])
    else $error("strobes closer than the host cycle allows");
  strobe_excl_a: assert property (!(wr && rd))
    else $error("write and read strobe together");

  pin_fall_c: cover property ($fell(int_b));
  status_low_c: cover property (rd && addr == cic_pkg::ADDR_STATUS && !int_b);
  enable_wr_c: cover property (wr && addr == cic_pkg::ADDR_IRQ_SOURCE_ENABLE);
endmodule : cic_sva

// File: can_controller_interrupt_logic_tb.sv
/*
  Self-checking testbench: host and device ends joined by the interface.
  Assumes the host end completes each register access within a few cycles.
*/
`timescale 1ns/1ps
module can_controller_interrupt_logic_tb;
  logic       clk_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       start_i = 1'b0, write_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic       busy_o, done_o, irq_o, sleep_o;
  logic       tx_evt = 1'b0, msg_err = 1'b0, sleep_req = 1'b0, activity = 1'b0, rx_valid = 1'b0;
  logic [2:0] tx_sel = 3'h0, code;
  logic [1:0] rx_evt = 2'h0, rx_full = 2'h0, rx_tgt = 2'h0;
  logic [8:0] rx_cnt = 9'h000, tx_cnt = 9'h000;
  int         failures = 0, check_count = 0, cycles = 0, i;
  logic [8:0] cnt_tab [7][2];
  logic [7:0] ec_tab [7];

  cic_if bif (.clk_i(clk_i), .rst_b_i(rst_b_i));
  cic_host u_cic_host (.bus(bif.host), .start_i(start_i), .write_i(write_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .irq_o(irq_o));
  cic_device u_cic_device (.bus(bif.dev), .tx_empty_evt_i(tx_evt), .tx_empty_lvl_i(3'h7),
    .rx_load_evt_i(rx_evt), .rx_full_lvl_i(rx_full), .rx_target_i(rx_tgt), .rx_valid_i(rx_valid),
    .tx_evt_sel_i(tx_sel), .msg_error_i(msg_err), .sleep_req_i(sleep_req),
    .bus_activity_i(activity), .rx_err_cnt_i(rx_cnt), .tx_err_cnt_i(tx_cnt), .sleep_o(sleep_o),
    .pending_source_code_o(code));
  cic_sva u_cic_sva (.clk_i(bif.clk_i), .rst_b_i(bif.rst_b_i), .addr(bif.addr),
    .wdata(bif.wdata), .wr(bif.wr), .rd(bif.rd), .rdata(bif.rdata), .int_b(bif.int_b));

  // ==========================================================================
  // Clock and hang guard.
  // ==========================================================================
  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // Cuts a hung run short and reports it as a mismatch.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end

  // ==========================================================================
  // Tasks.
  // ==========================================================================
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One host access; read data are sampled once the host has settled them.
  task automatic host_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    start_i <= 1'b1;
    write_i <= wr;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    start_i <= 1'b0;
    for (int k = 0; k < 10; k++) begin
      @(posedge clk_i);
      #1;
      if (done_o === 1'b1) break;
    end
    check({6'h00, busy_o, done_o}, 8'h03);
    @(posedge clk_i);
    #1;
    check({6'h00, busy_o, done_o}, 8'h00);
  endtask : host_op

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    host_op(1'b1, a, d);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    host_op(1'b0, a, 8'h00);
    check(rdata_o, exp);
  endtask : rd_reg

  // Lets one edge pass, then releases every event pulse.
  task automatic end_pulse();
    @(posedge clk_i);
    {tx_evt, msg_err, sleep_req, rx_valid, rx_evt} <= '0;
    @(posedge clk_i);
    #1;
  endtask : end_pulse

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // ==========================================================================
  // Test sequence.
  // ==========================================================================
  initial begin
    cnt_tab = '{'{9'h05F, 9'h000}, '{9'h060, 9'h000}, '{9'h080, 9'h000}, '{9'h000, 9'h060},
                '{9'h000, 9'h080}, '{9'h000, 9'h0FF}, '{9'h000, 9'h100}};
    ec_tab  = '{8'h00, 8'h03, 8'h0B, 8'h05, 8'h15, 8'h15, 8'h35};
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd_reg(cic_pkg::ADDR_IRQ_SOURCE_ENABLE, 8'h00);
    rd_reg(cic_pkg::ADDR_IRQ_SOURCE_FLAGS, 8'h00);
    rd_reg(cic_pkg::ADDR_STATUS, 8'h00);
    wr_reg(cic_pkg::ADDR_IRQ_SOURCE_ENABLE, 8'hA5);
    rd_reg(cic_pkg::ADDR_IRQ_SOURCE_ENABLE, 8'hA5);
    rd_reg(8'h10, 8'h00);
    $display("Test reset and enable register done");
    // Receive buffer 0 full, then cleared by the host.
    wr_reg(cic_pkg::ADDR_IRQ_SOURCE_ENABLE, 8'hFF);
    @(posedge clk_i) rx_evt <= 2'h1;
    end_pulse();
    check({5'h00, code}, {5'h00, cic_pkg::CODE_RX0});
    rd_reg(cic_pkg::ADDR_IRQ_SOURCE_FLAGS, 8'h01);
    wr_reg(cic_pkg::ADDR_IRQ_SOURCE_FLAGS, 8'h00);
    check({7'h00, irq_o}, 8'h00);
    // Both receive buffers at once: buffer 0 outranks buffer 1.
    @(posedge clk_i) rx_evt <= 2'h3;
    end_pulse();
    check({5'h00, code}, {5'h00, cic_pkg::CODE_RX0});
    wr_reg(cic_pkg::ADDR_IRQ_SOURCE_FLAGS, 8'h02);
    check({5'h00, code}, {5'h00, cic_pkg::CODE_RX1});
    wr_reg(cic_pkg::ADDR_IRQ_SOURCE_FLAGS, 8'h00);
    check({7'h00, irq_o}, 8'h00);
    // Each transmit buffer in turn.
    for (i = 0; i < 3; i++) begin
      @(posedge clk_i);
      tx_evt <= 1'b1;
      tx_sel <= 3'h1 << i;
      end_pulse();
      check({5'h00, code}, {5'h00, cic_pkg::CODE_TX0 + 3'(i)});
      rd_reg(cic_pkg::ADDR_IRQ_SOURCE_FLAGS, 8'h04 << i);
      wr_reg(cic_pkg::ADDR_IRQ_SOURCE_FLAGS, 8'h00);
    end
    $display("Test receive and transmit sources done");
    // Disabled sources: transmit refused, message error flagged without pin.
    wr_reg(cic_pkg::ADDR_IRQ_SOURCE_ENABLE, 8'h00);
    @(posedge clk_i);
    tx_evt <= 1'b1;
    tx_sel <= 3'h1;
    msg_err <= 1'b1;
    end_pulse();
    check({7'h00, irq_o}, 8'h00);
    rd_reg(cic_pkg::ADDR_IRQ_SOURCE_FLAGS, 8'h80);
    wr_reg(cic_pkg::ADDR_IRQ_SOURCE_ENABLE, 8'h80);
    check({7'h00, irq_o}, 8'h01);
    wr_reg(cic_pkg::ADDR_IRQ_SOURCE_FLAGS, 8'h00);
    $display("Test disabled sources done");
    // Wake from sleep on bus activity.
    wr_reg(cic_pkg::ADDR_IRQ_SOURCE_ENABLE, 8'hFF);
    @(posedge clk_i) sleep_req <= 1'b1;
    end_pulse();
    check({7'h00, sleep_o}, 8'h01);
    @(posedge clk_i) activity <= 1'b1;
    @(posedge clk_i) activity <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    check({7'h00, sleep_o}, 8'h00);
    check({5'h00, code}, {5'h00, cic_pkg::CODE_WAKE});
    wr_reg(cic_pkg::ADDR_IRQ_SOURCE_FLAGS, 8'h00);
    rd_reg(cic_pkg::ADDR_IRQ_SOURCE_FLAGS, 8'h00);
    $display("Test wake done");
    // Overrun into an occupied buffer; clear refused until overrun is gone.
    @(posedge clk_i);
    rx_full <= 2'h1;
    rx_tgt <= 2'h1;
    rx_valid <= 1'b1;
    end_pulse();
    rd_reg(cic_pkg::ADDR_ERROR_CONDITION, 8'h40);
    check({5'h00, code}, {5'h00, cic_pkg::CODE_ERR});
    wr_reg(cic_pkg::ADDR_IRQ_SOURCE_FLAGS, 8'h00);
    rd_reg(cic_pkg::ADDR_IRQ_SOURCE_FLAGS, 8'h20);
    rd_reg(cic_pkg::ADDR_ERROR_CONDITION, 8'h40);
    wr_reg(cic_pkg::ADDR_ERROR_CONDITION, 8'h00);
    wr_reg(cic_pkg::ADDR_IRQ_SOURCE_FLAGS, 8'h00);
    rd_reg(cic_pkg::ADDR_IRQ_SOURCE_FLAGS, 8'h00);
    @(posedge clk_i) rx_full <= 2'h0;
    $display("Test overrun done");
    // Error counter thresholds, error-state source disabled.
    wr_reg(cic_pkg::ADDR_IRQ_SOURCE_ENABLE, 8'h00);
    for (i = 0; i < 7; i++) begin
      @(posedge clk_i);
      rx_cnt <= cnt_tab[i][0];
      tx_cnt <= cnt_tab[i][1];
      rd_reg(cic_pkg::ADDR_ERROR_CONDITION, ec_tab[i]);
    end
    $display("Test error thresholds done");
    finish_test();
  end
endmodule : can_controller_interrupt_logic_tb
